// [common/dpw_map.svh]
// register map, field positions, reset values and opcodes of the wiper slave
// Behaviour
// - wiper register value drives tap selection monotonically
// - wiper register loads 80h at reset
// - wiper at 0, control at 10h, defaults
// - sample serial input on rising clock, selected
// - change serial output on falling clock edge
// - control bit 1 selects push-pull or open-drain
// - deselected: output high impedance, standby
// - control bit 6 low asserts shutdown
// - wiper register kept through shutdown
// - mode 0, master drives clock and select
// - every byte travels most significant bit first
// - first byte: opcode 7:5, address 4:0
// - address 0/1 wiper, 10000 control register
// - decode nop, control read/write, addressed read/write
// - write applied on chip select rising edge
// - read echoes instruction byte three, data byte four
// - echo byte is 111 plus address
// - input passes to output delayed one frame
`ifndef DPW_MAP_SVH
`define DPW_MAP_SVH
// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define DPW_ADDR_WIPER0 5'h00
`define DPW_ADDR_WIPER1 5'h01
`define DPW_ADDR_ACCESS 5'h10
`define DPW_RESET_WIPER 8'h80
`define DPW_RESET_ACCESS 8'h40
`define DPW_BIT_SHUTDOWN_N_BIT_N 6
`define DPW_BIT_OPEN_DRAIN 1
`define DPW_ACCESS_MASK 8'h42
// ----------------------------------------------------------------
// opcodes and frame layout
// ----------------------------------------------------------------
`define DPW_OP_NOP 3'h0
`define DPW_OP_ACC_RD 3'h1
`define DPW_OP_ACC_WR 3'h3
`define DPW_OP_ADR_RD 3'h4
`define DPW_OP_ADR_WR 3'h6
`define DPW_ECHO_TAG 3'h7
`define DPW_FRAME_BITS 16
`endif

// [common/dpw_pkg.sv]
// types shared by the wiper slave
package dpw_pkg;
    typedef enum logic [1:0] {
        DPW_IDLE = 2'h0,
        DPW_ACTIVE = 2'h1
    } dpw_link_type;
endpackage

// [hw/dpw_sync.sv]
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module dpw_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic ref_clk, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic async_in, // pin level
    output logic level, // synchronised level
    output logic rise, // one-cycle pulse on rising edge
    output logic fall // one-cycle pulse on falling edge
);
    logic meta;
    logic prev;
    // ----------------------------------------------------------------
    // first flop feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            meta <= INIT;
            level <= INIT;
            prev <= INIT;
        end
        else
        begin
            meta <= async_in;
            level <= meta;
            prev <= level;
        end
    end
    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule
`default_nettype wire

// [hw/dpw_slave.sv]
// spi mode-0 slave holding the wiper and access control registers
`timescale 1ns/1ps
`default_nettype none
`include "dpw_map.svh"
module dpw_slave
    import dpw_pkg::*;
(
    input wire logic ref_clk, // 100 MHz system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic sck, // serial clock from master
    input wire logic cs_n, // chip select, active low
    input wire logic sdi, // serial data in
    output logic sdo_out, // serial data out level
    output logic sdo_oe_n, // serial out enable, low drives
    output logic [7:0] wiper_tap, // tap selection
    output logic shutdown, // array open, wiper to low terminal
    output logic [7:0] wiper_position, // wiper register
    output logic [7:0] access_control // access control register
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic sck_lvl, sck_rise, sck_fall;
    logic cs_lvl, cs_rise, cs_fall;
    logic sdi_lvl;
    dpw_sync #(.INIT(1'b0)) u_sck (.ref_clk(ref_clk), .rstn(rstn), .async_in(sck),
        .level(sck_lvl), .rise(sck_rise), .fall(sck_fall));
    dpw_sync #(.INIT(1'b1)) u_cs (.ref_clk(ref_clk), .rstn(rstn), .async_in(cs_n),
        .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
    dpw_sync #(.INIT(1'b0)) u_sdi (.ref_clk(ref_clk), .rstn(rstn), .async_in(sdi),
        .level(sdi_lvl), .rise(), .fall());

    // ----------------------------------------------------------------
    // frame state
    // ----------------------------------------------------------------
    dpw_link_type link;
    logic armed; // a falling select was seen since reset
    logic [5:0] bit_cnt; // bits received this frame, saturating
    logic [7:0] shift_in; // byte being received
    logic [7:0] instr; // first byte of frame
    logic [7:0] data_byte; // latest complete data byte
    logic [15:0] chain; // one-frame delay line for daisy chain
    logic [7:0] shift_out; // byte being sent in a read
    logic rd_pend; // read instruction latched in byte one
    logic [4:0] rd_addr;
    logic use_read; // output comes from read data
    logic sdo_bit;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic is_wiper(input logic [4:0] a);
        return (a == `DPW_ADDR_WIPER0) || (a == `DPW_ADDR_WIPER1);
    endfunction

    wire active = (link == DPW_ACTIVE);
    wire take_bit = active & sck_rise & ~cs_lvl;
    wire [7:0] next_shift = {shift_in[6:0], sdi_lvl};
    wire byte_done = take_bit & (bit_cnt[2:0] == 3'h7);
    wire [2:0] opc = instr[7:5];
    wire [4:0] adr = instr[4:0];
    wire [2:0] new_opc = next_shift[7:5];
    wire [4:0] new_adr = next_shift[4:0];
    wire full_frame = bit_cnt >= 6'd16;
    wire wr_acc = (opc == `DPW_OP_ACC_WR)
        || ((opc == `DPW_OP_ADR_WR) && (adr == `DPW_ADDR_ACCESS));
    wire wr_wip = (opc == `DPW_OP_ADR_WR) && is_wiper(adr);
    wire commit = cs_rise & active & full_frame;
    wire new_rd = (new_opc == `DPW_OP_ACC_RD) || (new_opc == `DPW_OP_ADR_RD);
    wire [4:0] new_rd_adr = (new_opc == `DPW_OP_ACC_RD) ? `DPW_ADDR_ACCESS : new_adr;
    wire [7:0] rd_data = is_wiper(rd_addr) ? wiper_position
        : (rd_addr == `DPW_ADDR_ACCESS) ? access_control : 8'h00;

    // ----------------------------------------------------------------
    // link state: idle until chip select falls after reset
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            link <= DPW_IDLE;
            armed <= 1'b0;
        end
        else
        begin
            if (cs_fall)
            begin
                link <= DPW_ACTIVE;
                armed <= 1'b1;
            end
            else if (cs_lvl)
                link <= DPW_IDLE;
        end
    end

    // ----------------------------------------------------------------
    // receive path: counter and shifter cleared at frame start
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || cs_fall)
        begin
            bit_cnt <= 6'h00;
            shift_in <= 8'h00;
        end
        else if (take_bit)
        begin
            shift_in <= next_shift;
            if (bit_cnt != 6'h3F)
                bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // instruction in byte one, newest data byte afterwards
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || cs_fall)
        begin
            instr <= 8'h00;
            data_byte <= 8'h00;
        end
        else if (byte_done)
        begin
            if (bit_cnt[5:3] == 3'h0)
                instr <= next_shift;
            else
                data_byte <= next_shift;
        end
    end

    // ----------------------------------------------------------------
    // registers: writes applied on chip select release
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            wiper_position <= `DPW_RESET_WIPER;
            access_control <= `DPW_RESET_ACCESS;
        end
        else if (commit)
        begin
            if (wr_wip)
                wiper_position <= data_byte;
            if (wr_acc)
                access_control <= data_byte & `DPW_ACCESS_MASK;
        end
    end

    // ----------------------------------------------------------------
    // read capture: echo in byte three, value in byte four
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || cs_fall)
        begin
            rd_pend <= 1'b0;
            rd_addr <= 5'h00;
        end
        else if (byte_done && bit_cnt[5:3] == 3'h0)
        begin
            rd_pend <= new_rd;
            rd_addr <= new_rd_adr;
        end
    end

    // ----------------------------------------------------------------
    // daisy-chain delay line, shifted with received bits
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            chain <= 16'h0000;
        else if (take_bit)
            chain <= {chain[14:0], sdi_lvl};
    end

    // output shifter loads at byte boundaries of a read
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || cs_fall)
        begin
            shift_out <= 8'h00;
            use_read <= 1'b0;
        end
        else if (byte_done && rd_pend && bit_cnt[5:3] == 3'h1)
        begin
            shift_out <= {`DPW_ECHO_TAG, rd_addr};
            use_read <= 1'b1;
        end
        else if (byte_done && rd_pend && bit_cnt[5:3] == 3'h2)
            shift_out <= rd_data;
        else if (byte_done && bit_cnt[5:3] == 3'h3)
            use_read <= 1'b0;
        else if (take_bit)
            shift_out <= {shift_out[6:0], 1'b0};
    end

    // ----------------------------------------------------------------
    // serial output changes on falling clock and when chip select falls
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            sdo_bit <= 1'b1;
        else if (cs_fall)
            sdo_bit <= chain[15];
        else if (active && sck_fall)
            sdo_bit <= use_read ? shift_out[7] : chain[15];
    end

    // open drain drives only low; deselected leaves pin released
    wire drive = active & ~cs_lvl;
    wire open_drain = access_control[`DPW_BIT_OPEN_DRAIN];
    assign sdo_out = open_drain ? 1'b0 : sdo_bit;
    assign sdo_oe_n = ~drive | (open_drain & sdo_bit);

    // ----------------------------------------------------------------
    // analog side controls
    // ----------------------------------------------------------------
    assign wiper_tap = wiper_position;
    assign shutdown = ~access_control[`DPW_BIT_SHUTDOWN_N_BIT_N];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // frame end, and the two byte boundaries at which a read loads the output
    sequence s_frame_end;
        cs_rise && active;
    endsequence
    sequence s_read_echo;
        byte_done && rd_pend && bit_cnt == 6'd15;
    endsequence
    sequence s_read_data;
        byte_done && rd_pend && bit_cnt == 6'd23;
    endsequence

    a_reset_values: assert property (@(posedge ref_clk)
        $rose(rstn) |-> wiper_position == 8'h80 && access_control == 8'h40)
        else $error("reset values wrong");
    a_deselect_hiz: assert property (@(posedge ref_clk) disable iff (!rstn)
        cs_lvl |-> sdo_oe_n)
        else $error("output driven while deselected");
    a_wiper_change: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(wiper_position) |-> $past(commit))
        else $error("wiper changed outside commit");
    a_short_discard: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_frame_end ##0 !full_frame |=> $stable(wiper_position)
            && $stable(access_control))
        else $error("short frame wrote");
    a_sdo_on_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(sdo_bit) && !$past(cs_fall) |-> $past(sck_fall))
        else $error("output changed off falling clock");
    a_shutdown_bit: assert property (@(posedge ref_clk) disable iff (!rstn)
        shutdown == !access_control[6] && wiper_tap == wiper_position)
        else $error("shutdown or tap wrong");
    a_frame_align: assert property (@(posedge ref_clk) disable iff (!rstn)
        cs_fall |=> bit_cnt == 6'h00)
        else $error("counter not cleared");
    a_echo_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_read_echo |=> shift_out[7:5] == 3'h7)
        else $error("echo tag wrong");
    a_open_drain: assert property (@(posedge ref_clk) disable iff (!rstn)
        access_control[1] && !sdo_oe_n |-> !sdo_out)
        else $error("open drain drove high");
    a_need_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
        !armed |-> !active)
        else $error("active before select fell");

    // ----------------------------------------------------------------
    // checks: register writes
    // ----------------------------------------------------------------
    // the register takes the newest complete data byte, never an older one
    a_wiper_commit: assert property (@(posedge ref_clk) disable iff (!rstn)
        commit && wr_wip |=> wiper_position == $past(data_byte))
        else $error("wiper commit value wrong");
    a_access_commit: assert property (@(posedge ref_clk) disable iff (!rstn)
        commit && wr_acc |=> access_control == ($past(data_byte) & `DPW_ACCESS_MASK))
        else $error("control commit value wrong");
    a_access_change: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(access_control) |-> $past(commit))
        else $error("control changed outside commit");
    // shutdown only gates the analog side, the stored tap must survive it
    a_shutdown_n_bit_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        shutdown && !$past(commit) |-> $stable(wiper_position))
        else $error("wiper moved in shutdown");

    // ----------------------------------------------------------------
    // checks: receive path
    // ----------------------------------------------------------------
    a_take_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(bit_cnt) && !$past(cs_fall) |-> $past(take_bit))
        else $error("bit counted without rising clock");
    a_count_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        take_bit && bit_cnt != 6'h3F |=> bit_cnt == $past(bit_cnt) + 6'h01)
        else $error("bit counter skipped");
    a_bit_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
        take_bit |=> shift_in[0] == $past(sdi_lvl))
        else $error("input bit not captured");
    a_idle_standby: assert property (@(posedge ref_clk) disable iff (!rstn)
        cs_lvl |=> !active)
        else $error("link active while deselected");

    // ----------------------------------------------------------------
    // checks: read and chain output
    // ----------------------------------------------------------------
    a_echo_addr: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_read_echo |=> shift_out[4:0] == $past(rd_addr))
        else $error("echo address wrong");
    a_read_value: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_read_data |=> shift_out == $past(rd_data))
        else $error("read value not loaded");
    a_read_sdo: assert property (@(posedge ref_clk) disable iff (!rstn)
        use_read && active && sck_fall |=> sdo_bit == $past(shift_out[7]))
        else $error("read bit not shifted out");
    a_chain_sdo: assert property (@(posedge ref_clk) disable iff (!rstn)
        !use_read && active && sck_fall |=> sdo_bit == $past(chain[15]))
        else $error("chain bit not passed on");
    a_chain_shift: assert property (@(posedge ref_clk) disable iff (!rstn)
        take_bit |=> chain[0] == $past(sdi_lvl))
        else $error("chain missed input bit");
endmodule
`default_nettype wire

// [testbench/dpw_spi_master.sv]
// spi mode-0 master model that drives the wiper slave's serial pins
`timescale 1ns/1ps
`default_nettype none
module dpw_spi_master
    import dpw_pkg::*;
(
    input wire logic ref_clk, // bench clock, pins move on its falling edge
    input wire logic sdo_pin, // resolved serial out level
    output var logic sck, // serial clock, stands low between frames
    output var logic cs_n, // chip select, active low
    output var logic sdi // serial data to the slave
);
    // ----------------------------------------------------------------
    // idle levels and frame task
    // ----------------------------------------------------------------
    // deselected at power-up so the first frame starts with a real falling edge
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // up to four bytes, msb first; eight cycles a half period gives 160 ns
    task automatic frame(input int nbytes, input logic [31:0] tx, output logic [31:0] rx);
        int i;
        rx = 32'h0;
        @(negedge ref_clk);
        cs_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        for (i = nbytes * 8 - 1; i >= 0; i--)
        begin
            sdi = tx[i];
            repeat (8) @(negedge ref_clk);
            rx = {rx[30:0], sdo_pin}; // sampled at the rising clock edge
            sck = 1'b1;
            repeat (8) @(negedge ref_clk);
            sck = 1'b0;
        end
        repeat (8) @(negedge ref_clk);
        cs_n = 1'b1;
        sdi = ~sdi; // released data must not look like the last bit
        repeat (8) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// [testbench/dpw_slave_tb.sv]
// self-checking bench for the wiper slave with a random spi master
`timescale 1ns/1ps
`default_nettype none
`include "dpw_map.svh"
module dpw_slave_tb
    import dpw_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    wire sck, cs_n, sdi, sdo_out, sdo_oe_n, shutdown, sdo_pin;
    wire [7:0] wiper_tap, wiper_position, access_control;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cs_high_cnt = 0;
    logic [31:0] seed = 32'h9D5F0C79;
    logic [31:0] rx, r;
    logic [7:0] d, wexp, v;
    logic [4:0] a;
    // ----------------------------------------------------------------
    // clock, pins and instances
    // ----------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    // pull-up stands in for an undriven line in either output mode
    assign sdo_pin = sdo_oe_n ? 1'b1 : sdo_out;
    dpw_slave u_dpw_slave (.ref_clk(ref_clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .wiper_tap(wiper_tap), .shutdown(shutdown),
        .wiper_position(wiper_position), .access_control(access_control));
    dpw_spi_master u_dpw_spi_master (.ref_clk(ref_clk), .sdo_pin(sdo_pin), .sck(sck),
        .cs_n(cs_n), .sdi(sdi));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // only the shutdown and output-type bits can be written
    function automatic logic [7:0] exp_acc(input logic [7:0] w);
        return w & `DPW_ACCESS_MASK;
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] op, input logic [4:0] ad, input logic [7:0] dat);
        u_dpw_spi_master.frame(2, {16'h0, op, ad, dat}, rx);
    endtask
    task automatic rd(input logic [2:0] op, input logic [4:0] ad, input logic [4:0] echo,
        input logic [7:0] exp);
        u_dpw_spi_master.frame(4, {op, ad, 24'h0}, rx);
        chk8(rx[15:8], {`DPW_ECHO_TAG, echo});
        chk8(rx[7:0], exp);
    endtask
    task automatic chk_regs(input logic [7:0] w, input logic [7:0] c);
        chk8(wiper_position, w);
        chk8(wiper_tap, w);
        chk8(access_control, c);
        chk1(shutdown, ~c[`DPW_BIT_SHUTDOWN_N_BIT_N]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // pin monitors
    // ----------------------------------------------------------------
    // deselected slave floats its output once the synchronisers have caught up
    always @(posedge ref_clk)
    begin
        cs_high_cnt <= cs_n ? cs_high_cnt + 1 : 0;
        if (rstn && cs_high_cnt > 5)
            chk1(sdo_oe_n, 1'b1);
        if (access_control[`DPW_BIT_OPEN_DRAIN] === 1'b1 && sdo_oe_n === 1'b0)
            chk1(sdo_out, 1'b0);
    end
    initial
    begin
        // roughly two and a half times the length of a clean run
        #400us;
        n_mismatch++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk_regs(`DPW_RESET_WIPER, `DPW_RESET_ACCESS);
        $display("test reset done");
        // both wiper addresses, end codes first then random
        for (int k = 0; k < 6; k++)
        begin
            r = xs();
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : r[7:0];
            a = {4'h0, r[8]};
            wr(`DPW_OP_ADR_WR, a, d);
            chk_regs(d, `DPW_RESET_ACCESS);
            rd(`DPW_OP_ADR_RD, a, a, d);
            wexp = d;
        end
        $display("test wiper access done");
        // both control opcodes; open drain and shutdown keep reads and wiper intact
        for (int k = 0; k < 5; k++)
        begin
            r = xs();
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : (k == 2) ? 8'h02 : r[7:0];
            if (k[0])
                wr(`DPW_OP_ACC_WR, r[12:8], v);
            else
                wr(`DPW_OP_ADR_WR, `DPW_ADDR_ACCESS, v);
            chk_regs(wexp, exp_acc(v));
            rd(`DPW_OP_ACC_RD, r[20:16], `DPW_ADDR_ACCESS, exp_acc(v));
            rd(`DPW_OP_ADR_RD, `DPW_ADDR_ACCESS, `DPW_ADDR_ACCESS, exp_acc(v));
        end
        wr(`DPW_OP_ACC_WR, 5'h00, `DPW_RESET_ACCESS);
        chk_regs(wexp, `DPW_RESET_ACCESS);
        $display("test control register done");
        // short frame, unmapped address, unknown opcode and nop leave registers alone
        u_dpw_spi_master.frame(1, {24'h0, `DPW_OP_ADR_WR, 5'h00}, rx);
        chk_regs(wexp, `DPW_RESET_ACCESS);
        wr(`DPW_OP_ADR_WR, 5'h05, 8'h11);
        wr(3'h7, 5'h00, 8'h22);
        wr(`DPW_OP_NOP, 5'h00, 8'h33);
        rd(`DPW_OP_ADR_RD, 5'h05, 5'h05, 8'h00);
        chk_regs(wexp, `DPW_RESET_ACCESS);
        // frame after the short one must align; last of several data bytes wins
        r = xs();
        u_dpw_spi_master.frame(3, {8'h0, `DPW_OP_ADR_WR, 5'h00, r[15:0]}, rx);
        chk_regs(r[7:0], `DPW_RESET_ACCESS);
        wexp = r[7:0];
        $display("test refused frames done");
        // non-read frame comes back out delayed by one two-byte unit
        r = xs();
        u_dpw_spi_master.frame(4, {`DPW_OP_NOP, r[28:0]}, rx);
        chk8(rx[15:8], {`DPW_OP_NOP, r[28:24]});
        chk8(rx[7:0], r[23:16]);
        chk_regs(wexp, `DPW_RESET_ACCESS);
        $display("test pass-through done");
        // second reset in mid-run restores defaults
        wr(`DPW_OP_ACC_WR, 5'h00, 8'h02);
        rstn = 1'b0;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk_regs(`DPW_RESET_WIPER, `DPW_RESET_ACCESS);
        rd(`DPW_OP_ADR_RD, 5'h00, 5'h00, `DPW_RESET_WIPER);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
